/* design/dal_datapath.sv */
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module dal_datapath
    import dal_pkg::*;
(
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              RST_N,

    // data memory bus register port
    input  wire logic [DAL_AW-1:0] DM_ADDR,
    input  wire logic [DAL_W-1:0]  DM_WDATA,
    input  wire logic              DM_WR,
    input  wire logic              DM_RD,
    output logic      [DAL_W-1:0]  DM_RDATA,

    // program memory bus write into the y operand file
    input  wire logic              PM_WR,
    input  wire logic              PM_SEL,
    input  wire logic [DAL_W-1:0]  PM_WDATA,

    // instruction from the sequencer
    input  wire dal_instr_t        INSTR,

    // output registers of the other units
    input  wire dal_units_t        UNITS,

    // result bus, status and bank
    output logic      [DAL_W-1:0]  RBUS,
    output var dal_flags_t         FLAGS,
    output logic                   BANK
);

    // control registers
    // status and mode words; operand words sit in the register files

    // arithmetic status and mode status
    dal_flags_t       arith_status_reg_q;
    dal_flags_t       arith_status_reg_d;
    logic             mode_status_reg_q;
    logic             mode_status_reg_d;

    // registered read data for the data memory port
    logic [DAL_W-1:0] rdata_q;

    // data memory port decode
    // decodes are plain logic so a strobe acts in its own cycle

    // one write strobe per operand file or register; AF has none
    wire dm_wr_ax  = DM_WR & ((DM_ADDR == IDX_AX0) | (DM_ADDR == IDX_AX1));
    wire dm_wr_ay  = DM_WR & ((DM_ADDR == IDX_AY0) | (DM_ADDR == IDX_AY1));
    wire dm_wr_ar  = DM_WR & (DM_ADDR == IDX_AR);
    wire dm_wr_st  = DM_WR & (DM_ADDR == IDX_ARITH_STATUS_REG);
    wire dm_wr_md  = DM_WR & (DM_ADDR == IDX_MODE_STATUS_REG);

    // word select inside each operand file
    wire dm_sel_x  = (DM_ADDR == IDX_AX1);
    wire dm_sel_y  = (DM_ADDR == IDX_AY1);

    // bank selection
    // the next bank is passed on so registered views never lag a switch

    // mode bit takes effect from the next cycle on
    assign mode_status_reg_d = dm_wr_md ? DM_WDATA[MODE_STATUS_REG_BANK] : mode_status_reg_q; // [RL15]

    wire bank    = mode_status_reg_q;                                    // [RL14]
    wire bank_nx = mode_status_reg_d;

    // instruction decode
    // exec gates every result write so an idle cycle leaves state alone

    wire exec      = INSTR.exec;
    wire dest_ar   = exec & (INSTR.dest == DS_AR);              // [RL10]
    wire dest_af   = exec & (INSTR.dest == DS_AF);              // [RL10]
    wire x_sel_ax1 = (INSTR.xsel == XS_AX1);
    wire y_sel_ay1 = (INSTR.ysel == YS_AY1);

    // x operand file
    // loaded from the data bus only; program bus writes go to the y file

    logic [DAL_W-1:0] ax_op;
    logic [DAL_W-1:0] ax_bus;

    // dual-ported: operand read and bus read are independent
    dal_opfile #(
        .W        (DAL_W)
    ) u_xfile (
        .clk      (CLK),
        .rst_n    (RST_N),
        .bank     (bank),
        .wr_en    (dm_wr_ax),                                   // [RL5]
        .wr_sel   (dm_sel_x),
        .wr_data  (DM_WDATA),
        .op_sel   (x_sel_ax1),
        .op_data  (ax_op),
        .bus_sel  (dm_sel_x),                                   // [RL6]
        .bus_data (ax_bus)
    );

    // y operand file
    // both buses may load it; a clash keeps the data bus word

    // data memory write wins over a program memory write in the same cycle
    wire              y_wr_en   = dm_wr_ay | PM_WR;             // [RL8]
    wire              y_wr_sel  = dm_wr_ay ? dm_sel_y : PM_SEL;
    wire [DAL_W-1:0]  y_wr_data = dm_wr_ay ? DM_WDATA : PM_WDATA;

    logic [DAL_W-1:0] ay_op;
    logic [DAL_W-1:0] ay_bus;

    dal_opfile #(
        .W        (DAL_W)
    ) u_yfile (
        .clk      (CLK),
        .rst_n    (RST_N),
        .bank     (bank),
        .wr_en    (y_wr_en),
        .wr_sel   (y_wr_sel),
        .wr_data  (y_wr_data),
        .op_sel   (y_sel_ay1),
        .op_data  (ay_op),
        .bus_sel  (dm_sel_y),                                   // [RL9]
        .bus_data (ay_bus)
    );

    // result and feedback registers
    // banked single words whose views are registered for the outputs

    logic [DAL_W-1:0] res;
    logic [DAL_W-1:0] ar_val;
    logic [DAL_W-1:0] af_val;

    // alu result wins over a data memory load in the same cycle
    wire             ar_wr_en   = dest_ar | dm_wr_ar;           // [RL11]
    wire [DAL_W-1:0] ar_wr_data = dest_ar ? res : DM_WDATA;

    dal_bankreg #(
        .W       (DAL_W)
    ) u_ar (
        .clk     (CLK),
        .rst_n   (RST_N),
        .bank    (bank),
        .bank_nx (bank_nx),
        .wr_en   (ar_wr_en),
        .wr_data (ar_wr_data),
        .rd_q    (ar_val)
    );

    dal_bankreg #(
        .W       (DAL_W)
    ) u_af (
        .clk     (CLK),
        .rst_n   (RST_N),
        .bank    (bank),
        .bank_nx (bank_nx),
        .wr_en   (dest_af),
        .wr_data (res),
        .rd_q    (af_val)
    );

    // operand selection
    // plain muxes; other unit words come straight off the result bus

    // x port: own file or any word of the shared result bus
    wire [DAL_W-1:0] x_opnd =
        ((INSTR.xsel == XS_AX0) | x_sel_ax1) ? ax_op :          // [RL4]
        (INSTR.xsel == XS_AR)  ? ar_val :
        (INSTR.xsel == XS_MR0) ? UNITS.mr0 :                    // [RL19]
        (INSTR.xsel == XS_MR1) ? UNITS.mr1 :
        (INSTR.xsel == XS_MR2) ? UNITS.mr2 :
        (INSTR.xsel == XS_SR0) ? UNITS.sr0 : UNITS.sr1;

    // y port: own file or the feedback register
    wire [DAL_W-1:0] y_opnd = (INSTR.ysel == YS_AF) ? af_val : ay_op; // [RL7]

    // carry_in is the stored carry flag
    wire cin = arith_status_reg_q.c;                                       // [RL2]

    // alu function
    // one adder serves all arithmetic so the flags have one source

    logic [DAL_W-1:0] add_a;
    logic [DAL_W-1:0] add_b;
    logic             add_c;
    logic             arith;
    logic [DAL_W-1:0] log_r;

    // every arithmetic op maps to a + b + c
    always_comb begin
        add_a = x_opnd;
        add_b = y_opnd;
        add_c = 1'b0;
        arith = 1'b1;
        log_r = WORD_ZERO;
        case (INSTR.op)
            OP_ADD: begin                                       // [RL16]
                add_c = 1'b0;
            end
            OP_ADDC: begin
                add_c = cin;
            end
            OP_SUBXY: begin
                add_b = ~y_opnd;
                add_c = 1'b1;
            end
            OP_SUBXYB: begin
                add_b = ~y_opnd;
                add_c = cin;
            end
            OP_SUBYX: begin
                add_a = y_opnd;
                add_b = ~x_opnd;
                add_c = 1'b1;
            end
            OP_SUBYXB: begin
                add_a = y_opnd;
                add_b = ~x_opnd;
                add_c = cin;
            end
            OP_NEGX: begin                                      // [RL17]
                add_a = WORD_ZERO;
                add_b = ~x_opnd;
                add_c = 1'b1;
            end
            OP_NEGY: begin
                add_a = WORD_ZERO;
                add_b = ~y_opnd;
                add_c = 1'b1;
            end
            OP_INCY: begin
                add_a = y_opnd;
                add_b = WORD_ZERO;
                add_c = 1'b1;
            end
            OP_DECY: begin
                add_a = y_opnd;
                add_b = WORD_ONES;
            end
            OP_PASSX: begin
                add_b = WORD_ZERO;
            end
            OP_PASSY: begin
                add_a = y_opnd;
                add_b = WORD_ZERO;
            end
            OP_ABSX: begin
                add_a = WORD_ZERO;
                add_b = x_opnd[SIGN] ? ~x_opnd : x_opnd;
                add_c = x_opnd[SIGN];
            end
            OP_AND: begin                                       // [RL18]
                arith = 1'b0;
                log_r = x_opnd & y_opnd;
            end
            OP_OR: begin
                arith = 1'b0;
                log_r = x_opnd | y_opnd;
            end
            OP_XOR: begin
                arith = 1'b0;
                log_r = x_opnd ^ y_opnd;
            end
            OP_NOTX: begin
                arith = 1'b0;
                log_r = ~x_opnd;
            end
            OP_NOTY: begin
                arith = 1'b0;
                log_r = ~y_opnd;
            end
            default: begin
                // clear and unused codes give zero
                add_a = WORD_ZERO;
                add_b = WORD_ZERO;
            end
        endcase
    end

    // 16-bit adder with carry out
    wire [DAL_W:0] sum = {1'b0, add_a} + {1'b0, add_b} + {{DAL_W{1'b0}}, add_c}; // [RL1]

    assign res = arith ? sum[DAL_W-1:0] : log_r;

    // status flags
    // overflow looks at the adder inputs, so subtracts see the inverted word

    dal_flags_t arith_status_reg_bus;
    dal_flags_t alu_flags;

    assign arith_status_reg_bus = dal_flags_t'(DM_WDATA[FLAG_W-1:0]);

    assign alu_flags.z = ~|res;                                 // [RL22]
    assign alu_flags.n = res[SIGN];                             // [RL23]
    assign alu_flags.c = arith & sum[DAL_W];                    // [RL21]
    // signs of the adder inputs agree but the result sign differs
    assign alu_flags.v = arith & (add_a[SIGN] == add_b[SIGN])
                       & (res[SIGN] != add_a[SIGN]);            // [RL20]
    assign alu_flags.s = x_opnd[SIGN];                          // [RL24]
    assign alu_flags.q = dm_wr_st ? arith_status_reg_bus.q : arith_status_reg_q.q;    // [RL24]

    // an executing op overrides a same-cycle status write except for its q bit
    assign arith_status_reg_d = exec     ? alu_flags :                     // [RL3]
                     dm_wr_st ? arith_status_reg_bus : arith_status_reg_q;

    // read data for the data memory port
    // a read returns the word stored before its own cycle

    // reads see values stored in earlier cycles
    wire [DAL_W-1:0] rd_val =
        ((DM_ADDR == IDX_AX0) | dm_sel_x) ? ax_bus :            // [RL12]
        ((DM_ADDR == IDX_AY0) | dm_sel_y) ? ay_bus :
        (DM_ADDR == IDX_AR)    ? ar_val :
        (DM_ADDR == IDX_AF)    ? af_val :
        (DM_ADDR == IDX_ARITH_STATUS_REG) ? {{(DAL_W-FLAG_W){1'b0}}, arith_status_reg_q} :
                                 {{(DAL_W-1){1'b0}}, mode_status_reg_q};

    // state update
    // status, mode and read data; the files update in their own modules

    // all registers update at the end of the cycle, reads use old values
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            arith_status_reg_q <= '0;
            mode_status_reg_q <= BANK_RST;
            rdata_q <= WORD_ZERO;
        end else begin
            arith_status_reg_q <= arith_status_reg_d;                                 // [RL13]
            mode_status_reg_q <= mode_status_reg_d;
            if (DM_RD) begin
                rdata_q <= rd_val;
            end
        end
    end

    // outputs
    // every output comes straight from a flip-flop

    assign DM_RDATA = rdata_q;
    assign RBUS     = ar_val;                                   // [RL11]
    assign FLAGS    = arith_status_reg_q;
    assign BANK     = mode_status_reg_q;

endmodule
`default_nettype wire

/* design/dal_pkg.sv */
// How it works
// RL1: operands X and Y and the result are all 16 bits wide.
// RL2: carry_in comes from the carry flag held in arith_status_reg.
// RL3: six flags are captured into arith_status_reg at the end of the cycle.
// RL4: X operand is x_operand_reg0/1 or a word on the shared result bus.
// RL5: X operand registers are read and written over the data_memory_bus.
// RL6: X file feeds the X port while either register drives the bus.
// RL7: Y operand is y_operand_reg0/1 or the alu_feedback_reg.
// RL8: Y registers use data_memory_bus and take program_memory_bus writes.
// RL9: Y file feeds the Y port while either register drives the bus.
// RL10: result goes to alu_feedback_reg, alu_result_reg, or nowhere.
// RL11: alu_result_reg drives both buses and loads from data_memory_bus.
// RL12: registers are read at cycle start and written at cycle end.
// RL13: every register may be read and written in the same cycle.
// RL14: two banks of result, feedback, X and Y registers, one active.
// RL15: bit 0 of mode_status_reg picks the bank, one means alternate.
// RL16: add, add with carry, both subtracts and both borrow subtracts.
// RL17: negate X or Y, increment, decrement, pass, clear, absolute X.
// RL18: bitwise and, or, xor of X and Y, and invert X or Y.
// RL19: X also takes multiplier and shifter words; three result targets.
// RL20: overflow flags a sign change the operand signs do not predict.
// RL21: carry flags a carry out of the top result bit.
// RL22: zero flag is the nor of all result bits.
// RL23: negative flag is the result sign bit.
// RL24: x sign flag is X operand msb; quotient flag left unchanged.
`default_nettype none
package dal_pkg;
    localparam int DAL_W  = 16;
    localparam int DAL_AW = 3;
    localparam int SIGN   = DAL_W - 1;
    // register indices on the data memory port
    localparam logic [DAL_AW-1:0] IDX_AX0   = 3'h0;
    localparam logic [DAL_AW-1:0] IDX_AX1   = 3'h1;
    localparam logic [DAL_AW-1:0] IDX_AY0   = 3'h2;
    localparam logic [DAL_AW-1:0] IDX_AY1   = 3'h3;
    localparam logic [DAL_AW-1:0] IDX_AR    = 3'h4;
    localparam logic [DAL_AW-1:0] IDX_AF    = 3'h5;
    localparam logic [DAL_AW-1:0] IDX_ARITH_STATUS_REG = 3'h6;
    localparam logic [DAL_AW-1:0] IDX_MODE_STATUS_REG = 3'h7;
    // mode bit position and reset values
    localparam int               MODE_STATUS_REG_BANK = 0;
    localparam logic             BANK_RST   = 1'b0;
    localparam logic [DAL_W-1:0] WORD_ZERO  = 16'h0000;
    localparam logic [DAL_W-1:0] WORD_ONES  = 16'hffff;
    // alu operations
    typedef enum logic [4:0] {
        OP_ADD    = 5'b00000,
        OP_ADDC   = 5'b00001,
        OP_SUBXY  = 5'b00010,
        OP_SUBXYB = 5'b00011,
        OP_SUBYX  = 5'b00100,
        OP_SUBYXB = 5'b00101,
        OP_NEGX   = 5'b00110,
        OP_NEGY   = 5'b00111,
        OP_INCY   = 5'b01000,
        OP_DECY   = 5'b01001,
        OP_PASSX  = 5'b01010,
        OP_PASSY  = 5'b01011,
        OP_CLR    = 5'b01100,
        OP_ABSX   = 5'b01101,
        OP_AND    = 5'b01110,
        OP_OR     = 5'b01111,
        OP_XOR    = 5'b10000,
        OP_NOTX   = 5'b10001,
        OP_NOTY   = 5'b10010
    } dal_op_t;
    // x port sources
    typedef enum logic [2:0] {
        XS_AX0 = 3'b000, XS_AX1 = 3'b001, XS_AR  = 3'b010, XS_MR0 = 3'b011,
        XS_MR1 = 3'b100, XS_MR2 = 3'b101, XS_SR0 = 3'b110, XS_SR1 = 3'b111
    } dal_xsel_t;
    // y port sources
    typedef enum logic [1:0] {
        YS_AY0 = 2'b00, YS_AY1 = 2'b01, YS_AF = 2'b10
    } dal_ysel_t;
    // result destinations
    typedef enum logic [1:0] {
        DS_NONE = 2'b00, DS_AR = 2'b01, DS_AF = 2'b10
    } dal_dest_t;
    // one instruction for this unit
    typedef struct packed {
        logic      exec;
        dal_op_t   op;
        dal_xsel_t xsel;
        dal_ysel_t ysel;
        dal_dest_t dest;
    } dal_instr_t;
    // status word layout, zero flag in bit 0
    typedef struct packed {
        logic q;
        logic s;
        logic c;
        logic v;
        logic n;
        logic z;
    } dal_flags_t;
    localparam int FLAG_W = $bits(dal_flags_t);
    // result words of the other units on the shared result bus
    typedef struct packed {
        logic [DAL_W-1:0] mr0;
        logic [DAL_W-1:0] mr1;
        logic [DAL_W-1:0] mr2;
        logic [DAL_W-1:0] sr0;
        logic [DAL_W-1:0] sr1;
    } dal_units_t;
endpackage
`default_nettype wire

/* design/dal_opfile.sv */
`timescale 1ns/100ps
`default_nettype none
module dal_opfile
    import dal_pkg::*;
#(
    parameter int W = DAL_W
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // active bank
    input  wire logic         bank,
    // write port
    input  wire logic         wr_en,
    input  wire logic         wr_sel,
    input  wire logic [W-1:0] wr_data,
    // operand read port
    input  wire logic         op_sel,
    output logic      [W-1:0] op_data,
    // bus read port
    input  wire logic         bus_sel,
    output logic      [W-1:0] bus_data
);
    // refuse widths the flag logic cannot serve
    if (W < 2) begin : g_chk
        $error("operand width too small");
    end

    // two banks of two words
    logic [W-1:0] regs_q [2][2];

    // two independent read ports see the stored value
    assign op_data  = regs_q[bank][op_sel];
    assign bus_data = regs_q[bank][bus_sel];

    // write lands in the active bank at cycle end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regs_q <= '{default: '0};
        end else if (wr_en) begin
            regs_q[bank][wr_sel] <= wr_data;
        end
    end
endmodule
`default_nettype wire

/* design/dal_bankreg.sv */
`timescale 1ns/100ps
`default_nettype none
module dal_bankreg
    import dal_pkg::*;
#(
    parameter int W = DAL_W
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // active bank now and next cycle
    input  wire logic         bank,
    input  wire logic         bank_nx,
    // write port
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    // registered view of the active bank
    output logic      [W-1:0] rd_q
);
    // refuse widths the flag logic cannot serve
    if (W < 2) begin : g_chk
        $error("register width too small");
    end

    logic [W-1:0] regs_q [2];
    logic [W-1:0] regs_d [2];

    // next contents
    always_comb begin
        regs_d = regs_q;
        if (wr_en) begin
            regs_d[bank] = wr_data;
        end
    end

    // rd_q always equals the word of the bank active in the coming cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regs_q <= '{default: '0};
            rd_q   <= '0;
        end else begin
            regs_q <= regs_d;
            rd_q   <= regs_d[bank_nx];
        end
    end
endmodule
`default_nettype wire

/* verif/dal_datapath_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module dal_datapath_checker
    import dal_pkg::*;
(
    // clock and reset
    input wire logic              CLK,
    input wire logic              RST_N,
    // register port
    input wire logic [DAL_AW-1:0] DM_ADDR,
    input wire logic [DAL_W-1:0]  DM_WDATA,
    input wire logic              DM_WR,
    input wire logic              DM_RD,
    input wire logic [DAL_W-1:0]  DM_RDATA,
    // program bus write
    input wire logic              PM_WR,
    input wire logic              PM_SEL,
    input wire logic [DAL_W-1:0]  PM_WDATA,
    // instruction and other units
    input wire dal_instr_t        INSTR,
    input wire dal_units_t        UNITS,
    // results
    input wire logic [DAL_W-1:0]  RBUS,
    input wire dal_flags_t        FLAGS,
    input wire logic              BANK
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // decoded requests
    wire logic ms_wr  = DM_WR && DM_ADDR == IDX_MODE_STATUS_REG;
    wire logic ar_wr  = DM_WR && DM_ADDR == IDX_AR;
    wire logic st_wr  = DM_WR && DM_ADDR == IDX_ARITH_STATUS_REG;
    wire logic ex_ar  = INSTR.exec && INSTR.dest == DS_AR && !ms_wr; // a bank switch hides RBUS

    // bank, flags and result register relations
    bank_follow_a: assert property (ms_wr |=> BANK == $past(DM_WDATA[MODE_STATUS_REG_BANK]))
        else $error("bank does not follow mode write");
    zero_flag_a: assert property (ex_ar |=> FLAGS.z == (RBUS == WORD_ZERO))
        else $error("zero flag wrong");
    neg_flag_a: assert property (ex_ar |=> FLAGS.n == RBUS[SIGN])
        else $error("negative flag wrong");
    mode_read_a: assert property (DM_RD && DM_ADDR == IDX_MODE_STATUS_REG
        |=> DM_RDATA == {15'h0000, $past(BANK)})
        else $error("mode read wrong");
    ar_read_a: assert property (DM_RD && DM_ADDR == IDX_AR |=> DM_RDATA == $past(RBUS))
        else $error("result register read wrong");
    pass_unit_a: assert property (ex_ar && INSTR.op == OP_PASSX && INSTR.xsel == XS_MR0
        |=> RBUS == $past(UNITS.mr0))
        else $error("unit word not passed");
    x_sign_a: assert property (INSTR.exec && INSTR.xsel == XS_SR1
        |=> FLAGS.s == $past(UNITS.sr1[SIGN]))
        else $error("x sign flag wrong");
    quot_hold_a: assert property (INSTR.exec && !st_wr |=> $stable(FLAGS.q))
        else $error("quotient flag moved");
    ar_hold_a: assert property (!ex_ar && !ar_wr && !ms_wr |=> $stable(RBUS))
        else $error("result register moved");
    logic_flags_a: assert property (INSTR.exec && INSTR.op == OP_XOR
        |=> !FLAGS.c && !FLAGS.v)
        else $error("logic op set carry or overflow");

    // main scenarios
    cover property (ex_ar && INSTR.op == OP_ADDC);
    cover property (ms_wr && DM_WDATA[MODE_STATUS_REG_BANK]);
    cover property (INSTR.exec && DM_WR && DM_ADDR == IDX_AX0);
endmodule

bind dal_datapath dal_datapath_checker chk (.CLK, .RST_N, .DM_ADDR, .DM_WDATA, .DM_WR,
    .DM_RD, .DM_RDATA, .PM_WR, .PM_SEL, .PM_WDATA, .INSTR, .UNITS, .RBUS, .FLAGS, .BANK);
`default_nettype wire

/* verif/dal_units_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dal_units_model
    import dal_pkg::*;
#(
    parameter logic [DAL_W-1:0] BASE = 16'h9ab0
) (
    // result words offered on the shared bus
    output var dal_units_t units
);
    // each word differs so a wrong x source shows up
    assign units = '{BASE, BASE + 16'h0001, BASE + 16'h0002, BASE + 16'h0003, BASE + 16'h0004};
endmodule
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench
    import dal_pkg::*;
;
    localparam logic [15:0] UB = 16'h9ab0;
    logic CLK, RST_N, DM_WR, DM_RD, PM_WR, PM_SEL, BANK, ec;
    logic [DAL_AW-1:0] DM_ADDR;
    logic [15:0] DM_WDATA, PM_WDATA, DM_RDATA, RBUS, xv, yv;
    logic [17:0] e;
    logic [15:0] xa [2] = '{16'h7fff, 16'h8000};
    logic [15:0] ya [2] = '{16'h0001, 16'hffff};
    dal_instr_t INSTR;
    dal_units_t UNITS;
    dal_flags_t FLAGS;
    dal_op_t op;
    int n_fail, n_checks;

    // far side and device
    dal_units_model #(.BASE(UB)) far (.units(UNITS));
    dal_datapath dut (.CLK, .RST_N, .DM_ADDR, .DM_WDATA, .DM_WR, .DM_RD, .DM_RDATA,
        .PM_WR, .PM_SEL, .PM_WDATA, .INSTR, .UNITS, .RBUS, .FLAGS, .BANK);

    // clock
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    // compare tasks and verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkf(input dal_flags_t got, input logic [5:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // register port and instruction drivers
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge CLK);
        DM_WR <= 1'b1;
        DM_ADDR <= a;
        DM_WDATA <= d;
        @(posedge CLK);
        DM_WR <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge CLK);
        DM_RD <= 1'b1;
        DM_ADDR <= a;
        @(posedge CLK);
        DM_RD <= 1'b0;
        #1;
        chk(DM_RDATA, exp);
    endtask
    task automatic ex(input dal_op_t o, input dal_xsel_t x, input dal_ysel_t y, input dal_dest_t d);
        @(posedge CLK);
        INSTR <= '{1'b1, o, x, y, d};
        @(posedge CLK);
        INSTR.exec <= 1'b0;
        #1;
    endtask

    // expected {overflow, carry, result}
    function automatic logic [17:0] ref_alu(input dal_op_t o, input logic [15:0] x, y,
                                            input logic ci);
        logic [16:0] s;
        logic [15:0] a, b;
        logic k, add;
        a = x;
        b = y;
        k = 1'b0;
        add = 1'b1;
        case (o)
            OP_ADD: ;
            OP_ADDC: k = ci;
            OP_SUBXY: begin b = ~y; k = 1'b1; end
            OP_SUBXYB: begin b = ~y; k = ci; end
            OP_SUBYX: begin a = y; b = ~x; k = 1'b1; end
            OP_SUBYXB: begin a = y; b = ~x; k = ci; end
            OP_NEGX: begin a = 16'h0000; b = ~x; k = 1'b1; end
            OP_NEGY: begin a = 16'h0000; b = ~y; k = 1'b1; end
            OP_INCY: begin a = y; b = 16'h0000; k = 1'b1; end
            OP_DECY: begin a = y; b = 16'hffff; end
            OP_ABSX: begin a = x[15] ? 16'h0000 : x; b = x[15] ? ~x : 16'h0000; k = x[15]; end
            default: add = 1'b0;
        endcase
        s = a + b + k;
        if (add) return {a[15] == b[15] && s[15] != a[15], s};
        case (o)
            OP_PASSX: return {2'b00, x};
            OP_PASSY: return {2'b00, y};
            OP_AND: return {2'b00, x & y};
            OP_OR: return {2'b00, x | y};
            OP_XOR: return {2'b00, x ^ y};
            OP_NOTX: return {2'b00, ~x};
            OP_NOTY: return {2'b00, ~y};
            default: return {2'b00, 16'h0000};
        endcase
    endfunction

    // watchdog
    initial begin
        repeat (5000) @(posedge CLK);
        n_fail++;
        end_sim();
    end

    // test sequence
    initial begin
        {RST_N, DM_WR, DM_RD, PM_WR, PM_SEL, ec} = 6'h00;
        {DM_ADDR, DM_WDATA, PM_WDATA} = 35'h0;
        INSTR = '0;
        repeat (10) @(posedge CLK);
        RST_N <= 1'b1;
        for (int a = 0; a < 8; a++) rd(3'(a), 16'h0000);
        $display("test reset done");
        for (int p = 0; p < 2; p++) begin
            xv = xa[p];
            yv = ya[p];
            wr(IDX_AX0, xv);
            wr(IDX_AY0, yv);
            rd(IDX_AX0, xv);
            for (int i = 0; i < 19; i++) begin
                op = dal_op_t'(i);
                e = ref_alu(op, xv, yv, ec);
                ec = e[16];
                ex(op, XS_AX0, YS_AY0, DS_AR);
                chk(RBUS, e[15:0]);
                chkf(FLAGS, {1'b0, xv[15], e[16], e[17], e[15], ~|e[15:0]});
            end
        end
        $display("test ops done");
        wr(IDX_AX1, 16'h1357);
        rd(IDX_AX1, 16'h1357);
        wr(IDX_AY1, 16'h2468);
        rd(IDX_AY1, 16'h2468);
        @(posedge CLK);
        {PM_WR, PM_SEL} <= 2'b11;
        PM_WDATA <= 16'h0ace;
        @(posedge CLK);
        PM_WR <= 1'b0;
        rd(IDX_AY1, 16'h0ace);
        wr(IDX_AF, 16'hffff);
        rd(IDX_AF, 16'h0000);
        wr(IDX_AR, 16'h5a5a);
        rd(IDX_AR, 16'h5a5a);
        chk(RBUS, 16'h5a5a);
        $display("test regs done");
        ex(OP_ADD, XS_AX1, YS_AY1, DS_AF);
        chk(RBUS, 16'h5a5a);
        ex(OP_PASSY, XS_AX0, YS_AF, DS_AR);
        chk(RBUS, 16'h1e25);
        ex(OP_NOTX, XS_AR, YS_AY0, DS_NONE);
        chk(RBUS, 16'h1e25);
        chkf(FLAGS, 6'h02);
        rd(IDX_ARITH_STATUS_REG, 16'h0002);
        rd(IDX_AF, 16'h1e25);
        wr(IDX_ARITH_STATUS_REG, 16'h0028);
        ex(OP_ADDC, XS_AX1, YS_AY1, DS_AR);
        chk(RBUS, 16'h1e26);
        chkf(FLAGS, 6'h20);
        for (int k = 3; k < 8; k++) begin
            ex(OP_PASSX, dal_xsel_t'(k), YS_AY0, DS_AR);
            chk(RBUS, UB + 16'(k - 3));
        end
        $display("test paths done");
        @(posedge CLK);
        INSTR <= '{1'b1, OP_PASSX, XS_AX0, YS_AY0, DS_AR};
        {DM_WR, DM_ADDR, DM_WDATA} <= {1'b1, IDX_AX0, 16'h0f0f};
        @(posedge CLK);
        INSTR.exec <= 1'b0;
        DM_WR <= 1'b0;
        #1;
        chk(RBUS, 16'h8000);
        ex(OP_PASSX, XS_AX0, YS_AY0, DS_AR);
        chk(RBUS, 16'h0f0f);
        wr(IDX_MODE_STATUS_REG, 16'hffff);
        rd(IDX_MODE_STATUS_REG, 16'h0001);
        chk({15'h0000, BANK}, 16'h0001);
        rd(IDX_AX0, 16'h0000);
        chk(RBUS, 16'h0000);
        wr(IDX_AX0, 16'h4444);
        wr(IDX_MODE_STATUS_REG, 16'h0000);
        rd(IDX_AX0, 16'h0f0f);
        chk(RBUS, 16'h0f0f);
        $display("test banks done");
        end_sim();
    end
endmodule
`default_nettype wire
